// [include/seehs_params.svh]
// Constants for the serial EEPROM hold and sequencing control block.
`ifndef SEEHS_PARAMS_SVH
`define SEEHS_PARAMS_SVH

// Instruction codes.
`define SEEHS_OP_WRSR             8'h01
`define SEEHS_OP_WRITE            8'h02
`define SEEHS_OP_READ             8'h03
`define SEEHS_OP_WRDI             8'h04
`define SEEHS_OP_READ_STATUS_CMD  8'h05
`define SEEHS_OP_WRITE_ENABLE_CMD 8'h06

// Bit counts that make a well-formed frame, and the saturation limit of the bit counter.
`define SEEHS_CMD_BITS      12'h008
`define SEEHS_WRSR_BITS     12'h010
`define SEEHS_WRITE_MIN     12'h020
`define SEEHS_CNT_MAX       12'hFFF

// Status byte layout.
`define SEEHS_ST_BUSY_BIT   0
`define SEEHS_ST_LATCH_BIT  1

// Internal write cycle time and system clock period.
`define SEEHS_TWC_NS        5000000
`define SEEHS_CLK_NS        100
`define SEEHS_TWC_CYCLES    (`SEEHS_TWC_NS / `SEEHS_CLK_NS)

`endif

// [include/seehs_pkg.sv]
// Types for the serial EEPROM hold and sequencing control block.
package seehs_pkg;

   // Sequencing states of the system-clock side.
   typedef enum logic [0:0] {
      ST_STANDBY,
      ST_ACTIVE
   } seehs_state_type;

   // State kept on the system clock.
   typedef struct packed {
      logic            cs_s1;
      logic            cs_s2;
      logic            cs_prev;
      logic            hold_s1;
      logic            hold_s2;
      logic            rd_s1;
      logic            rd_s2;
      seehs_state_type st;
      logic            ready;
      logic            write_enable_latch;
      logic            busy;
      logic [15:0]     timer;
      logic            start;
      logic            so_oe;
   } seehs_sys_type;

   // State kept on the serial clock.
   typedef struct packed {
      logic [7:0]  shreg;
      logic [7:0]  opcode;
      logic [11:0] count;
      logic [7:0]  stat;
      logic        so_bit;
      logic        latch_s1;
      logic        latch_s2;
      logic        busy_s1;
      logic        busy_s2;
   } seehs_link_type;

endpackage

// [src/seehs_ctrl.sv]
// Serial EEPROM control slice: hold, power-on sequencing and write-cycle start.
`timescale 1ns/10ps
`default_nettype none
`include "seehs_params.svh"

module seehs_ctrl #(
   parameter int WRITE_CYCLES = `SEEHS_TWC_CYCLES
) (
   input  wire logic SYS_CLK,
   input  wire logic NRST,
   input  wire logic SCK,
   input  wire logic CS_N,
   input  wire logic SI,
   input  wire logic HOLD_N,
   output var  logic SO,
   output var  logic SO_OE,
   output var  logic WRITE_START,
   output var  logic WRITE_BUSY,
   output var  logic WRITE_ENABLED,
   output var  logic DEVICE_READY
);

   seehs_pkg::seehs_sys_type  r;
   seehs_pkg::seehs_sys_type  next_r;
   seehs_pkg::seehs_link_type lr;
   seehs_pkg::seehs_link_type next_lr;
   logic                      armed;
   logic                      rd_active;
   logic                      cs_fall;
   logic                      cs_rise;
   logic [11:0]               lcnt;
   logic [7:0]                lsh;
   logic [7:0]                stat_val;

   // Saturating increment of the serial bit counter.
   function automatic logic [11:0] seehs_inc(input logic [11:0] v);
      seehs_inc = (v == `SEEHS_CNT_MAX) ? v : v + 12'h001;
   endfunction

   // True when a frame held a whole number of bytes.
   function automatic logic seehs_aligned(input logic [11:0] v);
      seehs_aligned = (v[2:0] == 3'h0);
   endfunction

   // Serial side: shifts on rising clock edges, freezes while paused.
   always_comb begin
      next_lr = lr;
      stat_val = 8'h00;
      lcnt = armed ? 12'h000 : lr.count;
      lsh = armed ? 8'h00 : lr.shreg;
      next_lr.latch_s1 = r.write_enable_latch;
      next_lr.latch_s2 = lr.latch_s1;
      next_lr.busy_s1 = r.busy;
      next_lr.busy_s2 = lr.busy_s1;
      if (HOLD_N) begin
         next_lr.shreg = {lsh[6:0], SI};
         next_lr.count = seehs_inc(lcnt);
         if (next_lr.count == `SEEHS_CMD_BITS) begin
            next_lr.opcode = next_lr.shreg;
         end
         // The status byte is reloaded at every byte boundary and repeats.
         if (next_lr.opcode == `SEEHS_OP_READ_STATUS_CMD && next_lr.count >= `SEEHS_CMD_BITS &&
             seehs_aligned(next_lr.count)) begin
            stat_val[`SEEHS_ST_BUSY_BIT] = lr.busy_s2;
            stat_val[`SEEHS_ST_LATCH_BIT] = lr.latch_s2;
            next_lr.so_bit = stat_val[7];
            next_lr.stat = {stat_val[6:0], 1'b0};
         end else begin
            next_lr.so_bit = lr.stat[7];
            next_lr.stat = {lr.stat[6:0], 1'b0};
         end
      end
   end

   // Serial side registers; they only move while the host clocks a frame.
   always_ff @(posedge SCK) begin
      lr <= next_lr;
   end

   // Frame start marker, set by chip select high, and status-read flag, cleared by chip select high.
   always_ff @(posedge SCK or posedge CS_N) begin
      if (CS_N) begin
         armed <= 1'b1;
         rd_active <= 1'b0;
      end else begin
         armed <= armed & ~HOLD_N;
         rd_active <= (next_lr.opcode == `SEEHS_OP_READ_STATUS_CMD) && (next_lr.count >= `SEEHS_CMD_BITS);
      end
   end

   // Chip select edges seen after synchronisation.
   assign cs_fall = r.cs_prev & ~r.cs_s2;
   assign cs_rise = ~r.cs_prev & r.cs_s2;

   // System side: sequencing, write enable latch and the write-cycle timer.
   always_comb begin
      next_r = r;
      next_r.cs_s1 = CS_N;
      next_r.cs_s2 = r.cs_s1;
      next_r.cs_prev = r.cs_s2;
      next_r.hold_s1 = HOLD_N;
      next_r.hold_s2 = r.hold_s1;
      next_r.rd_s1 = rd_active;
      next_r.rd_s2 = r.rd_s1;
      next_r.start = 1'b0;
      // The internal write runs to its end whatever the host does.
      if (r.busy) begin
         if (r.timer == 16'h0000) begin
            next_r.busy = 1'b0;
            next_r.write_enable_latch = 1'b0;
         end else begin
            next_r.timer = r.timer - 16'h0001;
         end
      end
      case (r.st)
         seehs_pkg::ST_STANDBY: begin
            if (cs_fall) begin
               next_r.st = seehs_pkg::ST_ACTIVE;
            end
         end
         seehs_pkg::ST_ACTIVE: begin
            if (cs_rise) begin
               next_r.st = seehs_pkg::ST_STANDBY;
               // Frame contents are stable here: the host has stopped the clock.
               if (!r.busy) begin
                  if (lr.opcode == `SEEHS_OP_WRITE_ENABLE_CMD && lr.count == `SEEHS_CMD_BITS) begin
                     next_r.write_enable_latch = 1'b1;
                  end else if (lr.opcode == `SEEHS_OP_WRDI && lr.count == `SEEHS_CMD_BITS) begin
                     next_r.write_enable_latch = 1'b0;
                  end else if (r.write_enable_latch &&
                               ((lr.opcode == `SEEHS_OP_WRSR && lr.count == `SEEHS_WRSR_BITS) ||
                               (lr.opcode == `SEEHS_OP_WRITE && lr.count >= `SEEHS_WRITE_MIN &&
                                lr.count != `SEEHS_CNT_MAX && seehs_aligned(lr.count)))) begin
                     next_r.busy = 1'b1;
                     next_r.start = 1'b1;
                     next_r.timer = 16'(WRITE_CYCLES - 1);
                  end
               end
            end
         end
         default: begin
            next_r.st = seehs_pkg::ST_STANDBY;
         end
      endcase
      next_r.ready = (next_r.st == seehs_pkg::ST_ACTIVE);
      // Output drives only during a status read that is not paused.
      next_r.so_oe = ~r.cs_s2 & r.hold_s2 & r.rd_s2 & (r.st == seehs_pkg::ST_ACTIVE);
   end

   // Power-on reset puts the block in standby with writes disabled.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Outputs come straight from registers.
   assign SO = lr.so_bit;
   assign SO_OE = r.so_oe;
   assign WRITE_START = r.start;
   assign WRITE_BUSY = r.busy;
   assign WRITE_ENABLED = r.write_enable_latch;
   assign DEVICE_READY = r.ready;

   // The output floats within one cycle of a synchronised pause.
   a_oe_hold_quiet: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !r.hold_s2 |=> !SO_OE)
      else $error("Serial output driven while paused.");

   // Leaving reset shows standby with writes disabled and no write running.
   a_reset_standby: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      $rose(NRST) |-> !DEVICE_READY && !WRITE_ENABLED && !WRITE_BUSY)
      else $error("Block not in standby after reset release.");

   // Ready state only follows a chip select falling edge.
   a_ready_on_fall: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      $rose(DEVICE_READY) |-> $past(cs_fall))
      else $error("Ready entered without a chip select fall.");

   // End of an internal write leaves the latch cleared.
   a_latch_clear_done: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      $fell(WRITE_BUSY) |-> !WRITE_ENABLED)
      else $error("Write enable latch still set after write.");

   // A write starts only on a chip select rise and stays busy for at least the next two cycles.
   a_start_on_rise: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      WRITE_START |-> $past(cs_rise) && WRITE_BUSY ##1 WRITE_BUSY[*2])
      else $error("Write start not tied to chip select rise.");

   // Frames ending during a running write change nothing.
   a_busy_ignores: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      cs_rise && r.busy && r.timer != 16'h0000 |=> WRITE_ENABLED == $past(WRITE_ENABLED) && !WRITE_START)
      else $error("Command acted on during internal write.");

   // A whole write enable frame sets the latch.
   a_enable_sets: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      cs_rise && !r.busy && r.st == seehs_pkg::ST_ACTIVE && lr.opcode == `SEEHS_OP_WRITE_ENABLE_CMD &&
      lr.count == `SEEHS_CMD_BITS |=> WRITE_ENABLED)
      else $error("Write enable command did not set the latch.");

   // Anything but a status read keeps the output floating.
   a_bad_op_float: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !r.rd_s2 |=> !SO_OE)
      else $error("Serial output driven outside a status read.");

   // Clock edges during a pause leave the bit position untouched.
   a_hold_freeze: assert property (@(posedge SCK) disable iff (CS_N)
      !HOLD_N && !armed |=> lr.count == $past(lr.count) && lr.shreg == $past(lr.shreg))
      else $error("Bit counter moved while paused.");

endmodule // seehs_ctrl

`default_nettype wire

// [tb/seehs_ctrl_bench.sv]
// Self-checking bench for the serial EEPROM control slice.
`timescale 1ns/10ps
`default_nettype none
module seehs_ctrl_bench;
   logic       sys_clk;
   logic       nrst;
   wire logic  sck, cs_n, si, hold_n, so, so_oe;
   wire logic  w_start, w_busy, w_en, ready;
   int         n_errors, checks_done, n_st, n_oe, n_rdy, s0, o0, r0;
   logic [7:0] rx;
   logic       oh;

   seehs_ctrl #(.WRITE_CYCLES(200)) i_seehs_ctrl (.SYS_CLK(sys_clk), .NRST(nrst), .SCK(sck),
      .CS_N(cs_n), .SI(si), .HOLD_N(hold_n), .SO(so), .SO_OE(so_oe), .WRITE_START(w_start),
      .WRITE_BUSY(w_busy), .WRITE_ENABLED(w_en), .DEVICE_READY(ready));
   seehs_host_model i_seehs_host_model (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
      .so(so), .so_oe(so_oe));

   // The system clock toggles every half period.
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Counts start pulses, enabled-output cycles and ready cycles.
   always @(posedge sys_clk) begin
      n_st <= n_st + int'(w_start === 1'b1);
      n_oe <= n_oe + int'(so_oe === 1'b1);
      n_rdy <= n_rdy + int'(ready === 1'b1);
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic fr(input logic [39:0] d, input int n, input int h = -1);
      s0 = n_st;
      o0 = n_oe;
      r0 = n_rdy;
      i_seehs_host_model.frame(d, n, h, rx, oh);
   endtask
   task automatic t_refused();
      chk({4'h0, w_en, w_busy, ready, so_oe}, 8'h00, "power-up state");
      fr(40'hA5, 8);
      chk(8'(n_oe - o0), 8'h00, "bad opcode drove output");
      chk(8'(n_rdy > r0), 8'h01, "never ready");
      fr(40'h02_0010_5A, 32);
      chk(8'(n_st - s0), 8'h00, "write without enable");
   endtask
   task automatic t_enable();
      fr(40'h06, 8);
      chk({7'h00, w_en}, 8'h01, "latch not set");
      fr(40'h0500, 16, 10);
      chk(rx, 8'h02, "status with hold");
      chk({7'h00, oh}, 8'h00, "output driven in pause");
      chk(8'(n_oe > o0), 8'h01, "status never driven");
      fr(40'h04, 8);
      chk({7'h00, w_en}, 8'h00, "disable not served");
      fr(40'h06, 8);
      chk({7'h00, w_en}, 8'h01, "latch not set again");
   endtask
   task automatic t_write();
      fr(40'h02_0010_5A, 32, 12);
      chk(8'(n_st - s0), 8'h01, "write not started");
      chk({7'h00, w_busy}, 8'h01, "not busy");
      fr(40'h0500, 16);
      chk(rx, 8'h03, "status in write");
      fr(40'h04, 8);
      chk({7'h00, w_en}, 8'h01, "command served in write");
      fr(40'h02_0020_A5, 32);
      chk(8'(n_st - s0), 8'h00, "array access in write");
      for (int k = 0; k < 400 && w_busy !== 1'b0; k++) @(posedge sys_clk);
      chk({6'h00, w_busy, w_en}, 8'h00, "latch kept after write");
      fr(40'h0500, 16);
      chk(rx, 8'h00, "status after write");
   endtask
   task automatic t_count_reset();
      fr(40'h06, 8);
      fr(40'h04_0020_B4, 33);
      chk(8'(n_st - s0), 8'h00, "odd count started write");
      fork
         fr(40'h02_0030_11, 32);
         begin
            repeat (8) @(posedge sys_clk);
            nrst <= 1'b0;
            repeat (3) @(posedge sys_clk);
            nrst <= 1'b1;
         end
      join
      chk({6'h00, w_en, w_busy}, 8'h00, "reset kept state");
      chk(8'(n_st - s0), 8'h00, "discarded frame wrote");
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Main sequence after a held reset.
   initial begin
      {n_errors, checks_done, n_st, n_oe, n_rdy} = '0;
      nrst = 1'b0;
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_refused();
      t_enable();
      t_write();
      t_count_reset();
      conclude();
   end
   // Watchdog cuts a hang short.
   initial begin
      #400000;
      n_errors++;
      conclude();
   end
endmodule // seehs_ctrl_bench
`default_nettype wire

// [tb/seehs_host_model.sv]
// Host serial controller model driving frames into the control slice.
`timescale 1ns/10ps
`default_nettype none
module seehs_host_model (
   output var  logic sck,
   output var  logic cs_n,
   output var  logic si,
   output var  logic hold_n,
   input  wire logic so,
   input  wire logic so_oe
);
   wire logic so_line;
   // A released output line is seen inverted, so bits taken outside the enable window come out wrong.
   assign so_line = so_oe ? so : ~so;
   // The bus idles deselected, with the clock still and no pause.
   // One early chip select rise sets the frame start marker and clears the status-read flag of the link side, which has no reset of its own.
   initial begin
      sck = 1'b0;
      cs_n = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
      #1 cs_n = 1'b1;
   end
   // Sends n bits MSB first, pauses before bit h, and gathers the bits after the opcode.
   task automatic frame(input logic [39:0] d, input int n, input int h,
                        output logic [7:0] rx, output logic oh);
      rx = 8'h00;
      oh = 1'b0;
      cs_n = 1'b0;
      #150;
      for (int i = 0; i < n; i++) begin
         if (i == 8) #600;
         if (i == h) begin
            hold_n = 1'b0;
            repeat (4) begin
               si = ~si;
               #16 sck = 1'b1;
               #16 sck = 1'b0;
            end
            #500 oh = so_oe;
            hold_n = 1'b1;
            #500; // The output enable needs a few system cycles to return.
         end
         si = d[n-1-i];
         if (i >= 8) rx = {rx[6:0], so_line};
         #16 sck = 1'b1;
         #16 sck = 1'b0;
      end
      #16 cs_n = 1'b1;
      si = ~si;
      #700;
   endtask
endmodule // seehs_host_model
`default_nettype wire
